// ==== dv/tb_top.sv ====
// self-checking bench for the operand addressing and add/subtract decoder
`timescale 1ns/1ps
module tb_top;
  // clock and reset
  logic clock = 1'b0;
  logic reset = 1'b1;
  // request side
  logic source_mode = 1'b0;
  logic decode_valid = 1'b0;
  opdec_pkg::form_t form = opdec_pkg::form_acc_reg;
  opdec_pkg::alu_op_t alu_op = opdec_pkg::op_add;
  logic [31:0] dest_operand = 32'h0;
  logic [31:0] src_operand = 32'h0;
  logic carry_flag = 1'b0;
  opdec_pkg::imm_kind_t imm_kind = opdec_pkg::imm_short8;
  logic [15:0] imm_field = 16'h0;
  logic [1:0] step_code = 2'h0;
  opdec_pkg::bit_kind_t bit_kind = opdec_pkg::legacy_bit_address;
  logic [7:0] bit_number = 8'h0;
  logic [23:0] bit_address = 24'h0;
  logic [2:0] bit_select = 3'h0;
  logic bit_sfr_space = 1'b0;
  logic bit_sfr_defined = 1'b0;
  opdec_pkg::branch_kind_t branch_kind = opdec_pkg::rel_target;
  logic [23:0] branch_field = 24'h0;
  logic [23:0] next_pc = 24'h0;
  // design outputs
  logic busy, exec_done, mode_held, result_valid, carry_out, step_error;
  logic bit_in_sfr, bit_error;
  logic [31:0] alu_result, imm_operand;
  logic [2:0] step_value, bit_position;
  logic [23:0] bit_byte_address, branch_target;
  logic [3:0] instr_bytes, instr_states;
  // tallies
  int bad_count = 0;
  int n_compared = 0;
  // expected lengths and states per form, binary then source
  localparam logic [3:0] BIN_B [14] = '{1, 2, 1, 2, 3, 3, 3, 4, 4, 4, 5, 5, 4, 4};
  localparam logic [3:0] BIN_S [14] = '{1, 1, 2, 1, 2, 3, 5, 3, 3, 4, 3, 4, 3, 4};
  localparam logic [3:0] SRC_B [14] = '{2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 4, 4, 3, 3};
  localparam logic [3:0] SRC_S [14] = '{2, 1, 3, 1, 1, 2, 4, 3, 2, 3, 2, 3, 2, 3};

  operand_addressing_add_sub i_operand_addressing_add_sub (
    .clock(clock), .reset(reset), .source_mode(source_mode), .decode_valid(decode_valid),
    .form(form), .alu_op(alu_op), .dest_operand(dest_operand), .src_operand(src_operand),
    .carry_flag(carry_flag), .imm_kind(imm_kind), .imm_field(imm_field),
    .step_code(step_code), .bit_kind(bit_kind), .bit_number(bit_number),
    .bit_address(bit_address), .bit_select(bit_select), .bit_sfr_space(bit_sfr_space),
    .bit_sfr_defined(bit_sfr_defined), .branch_kind(branch_kind),
    .branch_field(branch_field), .next_pc(next_pc), .busy(busy), .exec_done(exec_done),
    .mode_held(mode_held), .result_valid(result_valid), .alu_result(alu_result),
    .carry_out(carry_out), .imm_operand(imm_operand), .step_value(step_value),
    .step_error(step_error), .bit_byte_address(bit_byte_address), .bit_in_sfr(bit_in_sfr),
    .bit_position(bit_position), .bit_error(bit_error), .branch_target(branch_target),
    .instr_bytes(instr_bytes), .instr_states(instr_states)
  );

  // free-running clock, 50 ns period
  initial begin
    forever #25 clock = ~clock;
  end

  // compare and tally
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one request; returns at the negedge where exec_done is seen, states in cnt
  task automatic go(input opdec_pkg::form_t f, input opdec_pkg::alu_op_t op,
                    output int cnt);
    int w;
    form = f;
    alu_op = op;
    decode_valid = 1'b1;
    @(negedge clock);
    decode_valid = 1'b0;
    w = 0;
    while (result_valid !== 1'b1 && w < 4) begin
      @(negedge clock);
      w++;
    end
    chk(result_valid, 1'b1);
    chk(busy, 1'b1);
    cnt = 0;
    while (exec_done !== 1'b1 && cnt < 16) begin
      @(negedge clock);
      cnt++;
    end
  endtask

  // every form in both modes
  task automatic timing_sweep();
    int cnt;
    for (int m = 0; m < 2; m++) begin
      source_mode = m[0];
      @(negedge clock);
      for (int i = 0; i < 14; i++) begin
        go(opdec_pkg::form_t'(i[3:0]), opdec_pkg::op_sub, cnt);
        chk(mode_held, m[0]);
        chk(instr_bytes, m ? SRC_B[i] : BIN_B[i]);
        chk(instr_states, m ? SRC_S[i] : BIN_S[i]);
        chk(cnt, m ? SRC_S[i] : BIN_S[i]);
      end
    end
  endtask

  // mode change and second request refused while busy
  task automatic mode_hold();
    source_mode = 1'b0;
    @(negedge clock);
    form = opdec_pkg::form_rr_dword;
    decode_valid = 1'b1;
    @(negedge clock);
    source_mode = 1'b1;
    form = opdec_pkg::form_acc_imm;
    for (int k = 1; k <= 5; k++) begin
      @(negedge clock);
      if (k == 3) decode_valid = 1'b0;
      chk(exec_done, k == 5);
      chk(mode_held, 1'b0);
      chk(instr_bytes, 4'h3);
    end
    repeat (2) @(negedge clock);
    chk(mode_held, 1'b1);
  endtask

  // arithmetic with and without the carry flag
  task automatic carry_ops();
    int cnt;
    dest_operand = 32'h000000ff;
    src_operand = 32'h00000001;
    carry_flag = 1'b1;
    go(opdec_pkg::form_acc_reg, opdec_pkg::sum_with_carry_op, cnt);
    chk(alu_result, 32'h00000001);
    chk(carry_out, 1'b1);
    dest_operand = 32'h00000010;
    go(opdec_pkg::form_acc_reg, opdec_pkg::difference_with_borrow_op, cnt);
    chk(alu_result, 32'h0000000e);
    chk(carry_out, 1'b0);
    go(opdec_pkg::form_acc_reg, opdec_pkg::op_add, cnt);
    chk(alu_result, 32'h00000011);
    carry_flag = 1'b0;
  endtask

  // immediate kinds and step codes
  task automatic immediates();
    int cnt;
    imm_field = 16'h5aa5;
    imm_kind = opdec_pkg::imm_short8;
    go(opdec_pkg::form_acc_imm, opdec_pkg::op_add, cnt);
    chk(imm_operand, 32'h000000a5);
    imm_kind = opdec_pkg::zero_extended_immediate;
    go(opdec_pkg::form_acc_imm, opdec_pkg::op_add, cnt);
    chk(imm_operand, 32'h00005aa5);
    imm_kind = opdec_pkg::one_extended_immediate;
    go(opdec_pkg::form_acc_imm, opdec_pkg::op_add, cnt);
    chk(imm_operand, 32'hffff5aa5);
    imm_kind = opdec_pkg::imm_step;
    for (int s = 0; s < 4; s++) begin
      step_code = s[1:0];
      go(opdec_pkg::form_acc_imm, opdec_pkg::op_add, cnt);
      chk(step_value, (s == 3) ? 3'h1 : (3'h1 << s));
      chk(step_error, s == 3);
    end
  endtask

  // bit address forms
  task automatic bit_addressing();
    int cnt;
    bit_kind = opdec_pkg::legacy_bit_address;
    bit_number = 8'h35;
    go(opdec_pkg::form_acc_reg, opdec_pkg::op_add, cnt);
    chk({bit_byte_address, bit_in_sfr, bit_position}, {24'h000026, 1'b0, 3'h5});
    bit_number = 8'h9b;
    go(opdec_pkg::form_acc_reg, opdec_pkg::op_add, cnt);
    chk({bit_byte_address, bit_in_sfr, bit_position}, {24'h000098, 1'b1, 3'h3});
    bit_kind = opdec_pkg::extended_bit_address;
    for (int c = 0; c < 5; c++) begin
      bit_address = (c == 0) ? 24'h00001f : (c == 1) ? 24'h000020 : 24'h00007d + c[23:0];
      bit_sfr_space = c > 3;
      bit_sfr_defined = 1'b0;
      go(opdec_pkg::form_acc_reg, opdec_pkg::op_add, cnt);
      chk(bit_error, c == 0 || c >= 3);
    end
    bit_sfr_defined = 1'b1;
    go(opdec_pkg::form_acc_reg, opdec_pkg::op_add, cnt);
    chk(bit_error, 1'b0);
    bit_sfr_space = 1'b0;
  endtask

  // branch target kinds
  task automatic branches();
    int cnt;
    logic [23:0] pc [6] = '{24'h001000, 24'h001000, 24'h000010, 24'h123456, 24'h123456,
                            24'h123456};
    logic [23:0] fld [6] = '{24'h000080, 24'h00007f, 24'h000080, 24'h0007ff, 24'h00abcd,
                             24'hfedcba};
    logic [23:0] exp [6] = '{24'h000f80, 24'h00107f, 24'hffff90, 24'h1237ff, 24'h12abcd,
                             24'hfedcba};
    for (int b = 0; b < 6; b++) begin
      branch_kind = opdec_pkg::branch_kind_t'((b < 3) ? 2'h0 : 2'(b - 2));
      next_pc = pc[b];
      branch_field = fld[b];
      go(opdec_pkg::form_acc_reg, opdec_pkg::op_add, cnt);
      chk(branch_target, exp[b]);
    end
  endtask

  // hang guard
  initial begin
    #2000000;
    bad_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    chk({busy, exec_done, mode_held, instr_bytes, branch_target}, 32'h0);
    mode_hold();
    timing_sweep();
    carry_ops();
    immediates();
    bit_addressing();
    branches();
    report_and_stop();
  end
endmodule // tb_top

// ==== hdl/operand_addressing_add_sub.sv ====
// operand addressing decode and add/subtract timing for the core
`timescale 1ns/1ps
`include "opdec_cfg.svh"

module operand_addressing_add_sub (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration
  input wire logic source_mode,
  // decode request
  input wire logic decode_valid,
  input wire opdec_pkg::form_t form,
  input wire opdec_pkg::alu_op_t alu_op,
  // operands
  input wire logic [31:0] dest_operand,
  input wire logic [31:0] src_operand,
  input wire logic carry_flag,
  // immediate fields
  input wire opdec_pkg::imm_kind_t imm_kind,
  input wire logic [15:0] imm_field,
  input wire logic [1:0] step_code,
  // bit address fields
  input wire opdec_pkg::bit_kind_t bit_kind,
  input wire logic [7:0] bit_number,
  input wire logic [23:0] bit_address,
  input wire logic [2:0] bit_select,
  input wire logic bit_sfr_space,
  input wire logic bit_sfr_defined,
  // branch fields
  input wire opdec_pkg::branch_kind_t branch_kind,
  input wire logic [23:0] branch_field,
  input wire logic [23:0] next_pc,
  // status
  output logic busy,
  output logic exec_done,
  output logic mode_held,
  // arithmetic
  output logic result_valid,
  output logic [31:0] alu_result,
  output logic carry_out,
  // immediate
  output logic [31:0] imm_operand,
  output logic [2:0] step_value,
  output logic step_error,
  // bit address
  output logic [23:0] bit_byte_address,
  output logic bit_in_sfr,
  output logic [2:0] bit_position,
  output logic bit_error,
  // branch
  output logic [23:0] branch_target,
  // timing
  output logic [3:0] instr_bytes,
  output logic [3:0] instr_states
);

  opdec_pkg::state_t st_r; // registered state
  opdec_pkg::state_t st_nxt; // next state
  timing_if tif (); // table link
  logic accept; // request taken this edge
  logic [1:0] width_sel; // 0 byte, 1 word, 2 dword
  logic [31:0] mask; // operand width mask
  logic [32:0] wide; // sum or difference with carry bit
  logic cin; // carry used by the operation
  logic [31:0] dm; // masked destination
  logic [31:0] sm; // masked source

  // timing lookup
  timing_table u_table (
    .tif(tif.table_side)
  );

  assign tif.form = form;
  assign tif.source_mode = st_r.mode;

  // request taken only while idle
  assign accept = decode_valid && (st_r.seq == opdec_pkg::seq_idle);

  // operand width by form
  always_comb begin
    case (form)
      opdec_pkg::form_rr_word: width_sel = 2'h1;
      opdec_pkg::form_w_short_direct_address: width_sel = 2'h1;
      opdec_pkg::form_w_long_direct_address: width_sel = 2'h1;
      opdec_pkg::form_rr_dword: width_sel = 2'h2;
      default: width_sel = 2'h0;
    endcase
  end

  // arithmetic datapath
  always_comb begin
    case (width_sel)
      2'h1: mask = 32'h0000ffff;
      2'h2: mask = 32'hffffffff;
      default: mask = 32'h000000ff;
    endcase
    dm = dest_operand & mask;
    sm = src_operand & mask;
    cin = (alu_op == opdec_pkg::sum_with_carry_op) ||
          (alu_op == opdec_pkg::difference_with_borrow_op) ? carry_flag : 1'b0;
    if (alu_op == opdec_pkg::op_sub || alu_op == opdec_pkg::difference_with_borrow_op) begin
      wide = {1'b0, dm} - {1'b0, sm} - {32'h00000000, cin};
    end else begin
      wide = {1'b0, dm} + {1'b0, sm} + {32'h00000000, cin};
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.exec_done = 1'b0;
    st_nxt.result_valid = 1'b0;
    case (st_r.seq)
      // idle: mode may change, requests taken
      opdec_pkg::seq_idle: begin
        // mode sampled only when no request is taken, so the
        // mode shown matches the one used for lengths and states
        st_nxt.mode = accept ? st_r.mode : source_mode;
        if (accept) begin
          st_nxt.seq = opdec_pkg::seq_exec;
          st_nxt.left = tif.states;
          st_nxt.result_valid = 1'b1;
          st_nxt.instr_bytes = tif.bytes;
          st_nxt.instr_states = tif.states;
          // result masked to operand width
          st_nxt.alu_result = wide[31:0] & mask;
          case (width_sel)
            2'h1: st_nxt.carry_out = wide[16];
            2'h2: st_nxt.carry_out = wide[32];
            default: st_nxt.carry_out = wide[8];
          endcase
          // immediate forms
          st_nxt.step_error = 1'b0;
          case (imm_kind)
            opdec_pkg::imm_short8: st_nxt.imm_operand = {24'h000000, imm_field[7:0]};
            opdec_pkg::zero_extended_immediate:
              st_nxt.imm_operand = {`IMM_ZERO_WORD, imm_field};
            opdec_pkg::one_extended_immediate:
              st_nxt.imm_operand = {`IMM_ONES_WORD, imm_field};
            default: st_nxt.imm_operand = 32'h00000000;
          endcase
          case (step_code)
            2'h0: st_nxt.step_value = `STEP_ONE;
            2'h1: st_nxt.step_value = `STEP_TWO;
            2'h2: st_nxt.step_value = `STEP_FOUR;
            default: begin
              st_nxt.step_value = `STEP_ONE;
              st_nxt.step_error = (imm_kind == opdec_pkg::imm_step);
            end
          endcase
          if (bit_kind == opdec_pkg::legacy_bit_address) begin
            st_nxt.bit_position = bit_number[2:0];
            st_nxt.bit_error = 1'b0;
            if (bit_number < `LEGACY_SFR_FIRST) begin
              st_nxt.bit_in_sfr = 1'b0;
              st_nxt.bit_byte_address = `LEGACY_RAM_BASE + {20'h00000, bit_number[6:3]};
            end else begin
              st_nxt.bit_in_sfr = 1'b1;
              st_nxt.bit_byte_address = {16'h0000, bit_number[7:3], 3'h0};
            end
          end else begin
            st_nxt.bit_position = bit_select;
            st_nxt.bit_in_sfr = bit_sfr_space;
            st_nxt.bit_byte_address = bit_address;
            st_nxt.bit_error = bit_sfr_space ? !bit_sfr_defined :
              (bit_address < `EXT_BIT_LOW) || (bit_address > `EXT_BIT_HIGH);
          end
          case (branch_kind)
            opdec_pkg::rel_target:
              st_nxt.branch_target = next_pc + {{16{branch_field[7]}}, branch_field[7:0]};
            opdec_pkg::block_target:
              st_nxt.branch_target = {next_pc[23:11], branch_field[10:0]};
            opdec_pkg::region_target:
              st_nxt.branch_target = {next_pc[23:16], branch_field[15:0]};
            default: st_nxt.branch_target = branch_field;
          endcase
        end
      end
      // exec: count down the execution states
      opdec_pkg::seq_exec: begin
        st_nxt.left = st_r.left - 4'h1;
        if (st_r.left <= 4'h1) begin
          st_nxt.seq = opdec_pkg::seq_idle;
          st_nxt.exec_done = 1'b1;
          st_nxt.left = 4'h0;
        end
      end
      default: st_nxt.seq = opdec_pkg::seq_idle;
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '0;
      st_r.seq <= opdec_pkg::seq_idle;
      st_r.mode <= `MODE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  // busy is the one-hot exec bit itself, no decode gate
  assign busy = st_r.seq[1];
  assign exec_done = st_r.exec_done;
  assign mode_held = st_r.mode;
  assign result_valid = st_r.result_valid;
  assign alu_result = st_r.alu_result;
  assign carry_out = st_r.carry_out;
  assign imm_operand = st_r.imm_operand;
  assign step_value = st_r.step_value;
  assign step_error = st_r.step_error;
  assign bit_byte_address = st_r.bit_byte_address;
  assign bit_in_sfr = st_r.bit_in_sfr;
  assign bit_position = st_r.bit_position;
  assign bit_error = st_r.bit_error;
  assign branch_target = st_r.branch_target;
  assign instr_bytes = st_r.instr_bytes;
  assign instr_states = st_r.instr_states;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // request taken in a given mode
  sequence take_bin;
    accept && !st_r.mode;
  endsequence

  sequence take_src;
    accept && st_r.mode;
  endsequence

  chk_short_imm: assert property (accept && imm_kind == opdec_pkg::imm_short8 |=>
    imm_operand == {24'h000000, $past(imm_field[7:0])})
    else $error("short immediate wrong");

  chk_ext_fill: assert property (accept && imm_kind == opdec_pkg::one_extended_immediate |=>
    imm_operand[31:16] == 16'hffff && imm_operand[15:0] == $past(imm_field))
    else $error("ones fill wrong");

  chk_step_set: assert property (result_valid |->
    step_value == 3'h1 || step_value == 3'h2 || step_value == 3'h4)
    else $error("step value out of set");

  chk_legacy_ram: assert property (accept && bit_kind == opdec_pkg::legacy_bit_address &&
    !bit_number[7] |=> !bit_in_sfr && bit_byte_address >= 24'h000020 &&
    bit_byte_address <= 24'h00002f)
    else $error("legacy bit not in ram window");

  chk_ext_range: assert property (result_valid && !bit_in_sfr && !bit_error &&
    $past(bit_kind) == opdec_pkg::extended_bit_address |->
    bit_byte_address >= 24'h000020 && bit_byte_address <= 24'h00007f)
    else $error("extended bit accepted out of range");

  chk_rel_target: assert property (accept && branch_kind == opdec_pkg::rel_target |=>
    branch_target == 24'($past(next_pc) + {{16{$past(branch_field[7])}}, $past(branch_field[7:0])}))
    else $error("relative target wrong");

  chk_block_kept: assert property (accept && branch_kind == opdec_pkg::block_target |=>
    branch_target[23:11] == $past(next_pc[23:11]))
    else $error("block target left its block");

  chk_region_kept: assert property (accept && branch_kind == opdec_pkg::region_target |=>
    branch_target[23:16] == $past(next_pc[23:16]))
    else $error("region target left its region");

  chk_full_target: assert property (accept && branch_kind == opdec_pkg::full_target |=>
    branch_target == $past(branch_field))
    else $error("full target altered");

  chk_carry_sum: assert property (accept && form == opdec_pkg::form_acc_reg &&
    alu_op == opdec_pkg::sum_with_carry_op |=>
    {carry_out, alu_result[7:0]} == 9'($past(dest_operand[7:0]) + $past(src_operand[7:0]) +
    $past(carry_flag)))
    else $error("carry sum wrong");

  chk_ind_timing: assert property (take_src ##0 form == opdec_pkg::form_acc_ind |=>
    instr_bytes == 4'h2 && instr_states == 4'h3 && busy ##1 busy ##1 busy ##1 exec_done)
    else $error("indirect source timing wrong");

  chk_imm_timing: assert property (take_bin ##0 form == opdec_pkg::form_acc_imm |=>
    instr_bytes == 4'h2 && instr_states == 4'h1 ##1 exec_done && !busy)
    else $error("immediate acc timing wrong");

  chk_dword_timing: assert property (take_bin ##0 form == opdec_pkg::form_rr_dword |=>
    instr_bytes == 4'h3 && instr_states == 4'h5 ##5 exec_done)
    else $error("dword timing wrong");

  chk_mode_hold: assert property (busy |=> $stable(mode_held))
    else $error("mode changed during execution");

  // mode kept across the accept edge
  chk_mode_taken: assert property (accept |=> mode_held == $past(st_r.mode))
    else $error("mode changed at accept");

endmodule // operand_addressing_add_sub

// ==== hdl/timing_table.sv ====
// byte counts and state counts per form and encoding mode
`timescale 1ns/1ps
`include "opdec_cfg.svh"
module timing_table (
  // lookup
  timing_if.table_side tif
);

  logic [15:0] entry; // packed table entry

  // table lookup by form
  always_comb begin
    case (tif.form)
      opdec_pkg::form_acc_reg: entry = `T_ACC_REG;
      opdec_pkg::form_acc_short_direct_address: entry = `T_ACC_SHORT_DIRECT_ADDRESS;
      opdec_pkg::form_acc_ind: entry = `T_ACC_IND;
      opdec_pkg::form_acc_imm: entry = `T_ACC_IMM;
      opdec_pkg::form_rr_byte: entry = `T_RR_BYTE;
      opdec_pkg::form_rr_word: entry = `T_RR_WORD;
      opdec_pkg::form_rr_dword: entry = `T_RR_DWORD;
      opdec_pkg::form_r_imm8: entry = `T_R_IMM8;
      opdec_pkg::form_r_short_direct_address: entry = `T_R_SHORT_DIRECT_ADDRESS;
      opdec_pkg::form_w_short_direct_address: entry = `T_W_SHORT_DIRECT_ADDRESS;
      opdec_pkg::form_r_long_direct_address: entry = `T_R_LONG_DIRECT_ADDRESS;
      opdec_pkg::form_w_long_direct_address: entry = `T_W_LONG_DIRECT_ADDRESS;
      opdec_pkg::form_r_ptr16: entry = `T_R_PTR16;
      opdec_pkg::form_r_ptr24: entry = `T_R_PTR24;
      default: entry = `T_ACC_REG;
    endcase
  end

  assign tif.bytes = tif.source_mode ? entry[7:4] : entry[15:12];
  assign tif.states = tif.source_mode ? entry[3:0] : entry[11:8];

endmodule // timing_table

// ==== include/opdec_cfg.svh ====
// constants for the operand addressing and add/subtract timing decoder
`ifndef OPDEC_CFG_SVH
`define OPDEC_CFG_SVH

// immediate forms
`define IMM_SHORT_BITS 8
`define IMM_ONES_WORD 16'hffff
`define IMM_ZERO_WORD 16'h0000
`define STEP_ONE 3'h1
`define STEP_TWO 3'h2
`define STEP_FOUR 3'h4

// bit addressing
`define LEGACY_RAM_BASE 24'h000020
`define LEGACY_SFR_FIRST 8'h80
`define EXT_BIT_LOW 24'h000020
`define EXT_BIT_HIGH 24'h00007f

// timing entries: {binary bytes, binary states, source bytes, source states}
`define T_ACC_REG 16'h1122
`define T_ACC_SHORT_DIRECT_ADDRESS 16'h2121
`define T_ACC_IND 16'h1223
`define T_ACC_IMM 16'h2121
`define T_RR_BYTE 16'h3221
`define T_RR_WORD 16'h3322
`define T_RR_DWORD 16'h3524
`define T_R_IMM8 16'h4333
`define T_R_SHORT_DIRECT_ADDRESS 16'h4332
`define T_W_SHORT_DIRECT_ADDRESS 16'h4433
`define T_R_LONG_DIRECT_ADDRESS 16'h5342
`define T_W_LONG_DIRECT_ADDRESS 16'h5443
`define T_R_PTR16 16'h4332
`define T_R_PTR24 16'h4433

// reset values
`define MODE_RESET 1'b0

`endif

// ==== include/opdec_pkg.sv ====
// types shared by the decoder and its timing table
package opdec_pkg;

  // instruction forms of the add/subtract family
  typedef enum logic [3:0] {
    form_acc_reg, form_acc_short_direct_address, form_acc_ind, form_acc_imm,
    form_rr_byte, form_rr_word, form_rr_dword, form_r_imm8,
    form_r_short_direct_address, form_w_short_direct_address, form_r_long_direct_address, form_w_long_direct_address,
    form_r_ptr16, form_r_ptr24
  } form_t;

  // arithmetic operation
  typedef enum logic [1:0] {
    op_add, op_sub, sum_with_carry_op, difference_with_borrow_op
  } alu_op_t;

  // immediate operand kinds
  typedef enum logic [1:0] {
    imm_short8, zero_extended_immediate, one_extended_immediate, imm_step
  } imm_kind_t;

  // bit addressing kinds
  typedef enum logic {legacy_bit_address, extended_bit_address} bit_kind_t;

  // branch target kinds
  typedef enum logic [1:0] {
    rel_target, block_target, region_target, full_target
  } branch_kind_t;

  // execution sequencer, one-hot
  typedef enum logic [1:0] {seq_idle = 2'b01, seq_exec = 2'b10} seq_t;

  // whole state of the decoder
  typedef struct packed {
    seq_t seq;
    logic mode;
    logic [3:0] left;
    logic result_valid;
    logic exec_done;
    logic [31:0] alu_result;
    logic carry_out;
    logic [31:0] imm_operand;
    logic [2:0] step_value;
    logic step_error;
    logic [23:0] bit_byte_address;
    logic bit_in_sfr;
    logic [2:0] bit_position;
    logic bit_error;
    logic [23:0] branch_target;
    logic [3:0] instr_bytes;
    logic [3:0] instr_states;
  } state_t;

endpackage

// ==== include/timing_if.sv ====
// link between the decoder and its timing table
`timescale 1ns/1ps
interface timing_if;
  opdec_pkg::form_t form; // form to look up
  logic source_mode; // high selects source encoding
  logic [3:0] bytes; // instruction length
  logic [3:0] states; // execution states
  modport table_side (input form, input source_mode, output bytes, output states);
  modport user_side (output form, output source_mode, input bytes, input states);
endinterface
